// file: dv/high_side_driver_control_tb.sv
// Self-checking bench for the high-side driver control block.
// Assumes the load model on the driver side and the checker bound in.
`timescale 1ns/1ps
`include "hs_driver_map.svh"
module high_side_driver_control_tb;
    // Stimulus and observed signals
    logic        mclk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic        lowPowerMode = 1'b0, cyclicSenseKeep = 1'b0, overtempRaw = 1'b0, highVoltageRaw = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWdata = 8'h00, regRdata, rdv, c;
    logic [1:0]  pwmChannel = 2'b00, loadOpen = 2'b00, loadShort = 2'b00;
    logic [1:0]  currentLimitRaw, openLoadRaw, driverGate, p, e;
    logic        regHit, overtempFlag, overtempIrq;
    int          miscompares = 0;
    int          nTests = 0;
    localparam logic [15:0] CTL  = `HSD_BASE_BLOCKING | {8'h00, `HSD_OFF_CONTROL};
    localparam logic [15:0] CTL2 = `HSD_BASE_NONBLOCKING | {8'h00, `HSD_OFF_CONTROL};
    localparam logic [15:0] STS  = `HSD_BASE_BLOCKING | {8'h00, `HSD_OFF_STATUS};

    high_side_driver_control uut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
        .pwmChannel(pwmChannel), .lowPowerMode(lowPowerMode), .cyclicSenseKeep(cyclicSenseKeep),
        .overtempRaw(overtempRaw), .highVoltageRaw(highVoltageRaw), .currentLimitRaw(currentLimitRaw),
        .openLoadRaw(openLoadRaw), .driverGate(driverGate), .overtempFlag(overtempFlag),
        .overtempIrq(overtempIrq));
    hs_load_model load (.driverGate(driverGate), .loadOpen(loadOpen), .loadShort(loadShort),
        .openLoadRaw(openLoadRaw), .currentLimitRaw(currentLimitRaw));

    // Free-running 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One-cycle strobes; held until the taking edge, then dropped
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        d = regRdata;
    endtask : rd

    // Gate lands one edge after the write is taken; two spare edges for slack
    task automatic gate(input logic [1:0] x);
        repeat (3) @(posedge mclk);
        #1;
        chk("driverGate", {6'h00, driverGate}, {6'h00, x});
    endtask : gate

    // Analog levels change, then pass the two-flop synchroniser
    task automatic analog(input logic ot, input logic hv);
        @(posedge mclk);
        overtempRaw <= ot;
        highVoltageRaw <= hv;
        repeat (3) @(posedge mclk);
    endtask : analog

    task automatic reportAndStop;
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : reportAndStop

    // Hang guard: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        reportAndStop;
    end

    // Test sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(CTL, rdv); chk("control reset", rdv, `HSD_CONTROL_RESET);
        rd(STS, rdv); chk("status reset", rdv, `HSD_STATUS_RESET);
        wr(CTL2, 8'h35); rd(CTL, rdv); chk("control alias", rdv, 8'h35);
        wr(STS, 8'hFF); rd(STS, rdv); chk("status read only", rdv, 8'h00);
        rd(16'h022A, rdv); chk("unmapped", rdv, 8'h00);
        $display("test registers done");
        @(posedge mclk); loadOpen <= 2'b11;
        for (int i = 0; i < 8; i++) begin
            c = {2'b00, i[1:0], 4'hF};
            p = i[2] ? 2'b10 : 2'b01;
            e = {p[c[5]], p[c[4]]};
            @(posedge mclk); pwmChannel <= p;
            wr(CTL, c); gate(e);
            rd(STS, rdv); chk("open load pwm", rdv, {6'h00, e});
        end
        @(posedge mclk); loadShort <= 2'b11;
        wr(CTL, 8'h01); gate(2'b01);
        rd(STS, rdv); chk("limit and open", rdv, 8'h05);
        @(posedge mclk); loadShort <= 2'b00; loadOpen <= 2'b00;
        $display("test pwm and load done");
        wr(CTL, 8'h83); gate(2'b11);
        analog(1'b1, 1'b0); gate(2'b00);
        chk("overtempFlag", {7'h00, overtempFlag}, 8'h01);
        chk("overtempIrq", {7'h00, overtempIrq}, 8'h01);
        rd(STS, rdv); chk("status overtemp", rdv, 8'h80);
        chk("flag after read", {7'h00, overtempFlag}, 8'h00);
        wr(CTL, 8'h83); gate(2'b00);
        analog(1'b0, 1'b0); gate(2'b00);
        wr(CTL, 8'h03); gate(2'b11);
        analog(1'b1, 1'b0); gate(2'b00);
        chk("masked irq", {7'h00, overtempIrq}, 8'h00);
        analog(1'b0, 1'b0); chk("flag held", {7'h00, overtempFlag}, 8'h01);
        rd(STS, rdv); chk("status cooled", rdv, 8'h00);
        chk("flag cleared", {7'h00, overtempFlag}, 8'h00);
        wr(CTL, 8'h03); gate(2'b11);
        $display("test overtemperature done");
        analog(1'b0, 1'b1); gate(2'b11);
        wr(CTL, 8'h43); gate(2'b00);
        wr(CTL, 8'h43); gate(2'b00);
        analog(1'b0, 1'b0); gate(2'b00);
        wr(CTL, 8'h43); gate(2'b11);
        $display("test high voltage done");
        @(posedge mclk); lowPowerMode <= 1'b1; gate(2'b00);
        @(posedge mclk); cyclicSenseKeep <= 1'b1; gate(2'b11);
        $display("test low power done");
        reportAndStop;
    end
endmodule : high_side_driver_control_tb

// file: dv/hs_driver_asserts.sv
// Port checks for the high-side driver control block.
// Assumes binding to that block; all signals sampled on mclk.
`timescale 1ns/1ps
`include "hs_driver_map.svh"
module hs_driver_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata,
    input wire logic        regHit,
    // Environment and outputs
    input wire logic [1:0]  pwmChannel,
    input wire logic        lowPowerMode,
    input wire logic        cyclicSenseKeep,
    input wire logic        overtempRaw,
    input wire logic        highVoltageRaw,
    input wire logic [1:0]  currentLimitRaw,
    input wire logic [1:0]  openLoadRaw,
    input wire logic [1:0]  driverGate,
    input wire logic        overtempFlag,
    input wire logic        overtempIrq
);
    // Status read in either window
    logic stsRead;
    assign stsRead = regRead && regAddr[7:0] == `HSD_OFF_STATUS && regAddr[15:9] == 7'h01;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_hit_decode: assert property (regHit == (regAddr[15:9] == 7'h01 && regAddr[7:1] == 7'h14))
        else $error("register hit decode wrong");
    a_unmapped_zero: assert property (regRead && !regHit |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_flag: assert property (overtempIrq |-> overtempFlag)
        else $error("interrupt without flag");
    a_ot_shutdown: assert property (overtempRaw [*4] |=> driverGate == 2'b00)
        else $error("gate on during overtemperature");
    a_ot_latch: assert property ($rose(overtempRaw) ##1 overtempRaw [*2] |-> ##[1:2] overtempFlag)
        else $error("overtemperature flag not set");
    a_read_clear: assert property (!overtempRaw [*4] ##0 stsRead |=> !overtempFlag)
        else $error("status read left flag set");
    a_open_off: assert property (driverGate == 2'b00 ##1 (stsRead && driverGate == 2'b00)
        |=> regRdata[1:0] == 2'b00)
        else $error("open load shown while off");
    a_clim_status: assert property ($stable(currentLimitRaw) [*3] ##0 stsRead
        |=> regRdata[3:2] == $past(currentLimitRaw))
        else $error("current limit bits wrong");
    a_ot_status: assert property (overtempRaw [*3] ##0 stsRead |=> regRdata[7])
        else $error("overtemperature bit not shown");
    a_low_power: assert property ((lowPowerMode && !cyclicSenseKeep) [*3] |=> driverGate == 2'b00)
        else $error("gate on in low power");
endmodule : hs_driver_asserts

bind high_side_driver_control hs_driver_asserts u_chk (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit), .pwmChannel(pwmChannel),
    .lowPowerMode(lowPowerMode), .cyclicSenseKeep(cyclicSenseKeep), .overtempRaw(overtempRaw),
    .highVoltageRaw(highVoltageRaw), .currentLimitRaw(currentLimitRaw), .openLoadRaw(openLoadRaw),
    .driverGate(driverGate), .overtempFlag(overtempFlag), .overtempIrq(overtempIrq));

// file: dv/hs_load_model.sv
// Behavioural model of the two high-side switches and their loads.
// Assumes resistive loads; the bench picks open or overloaded loads.
`timescale 1ns/1ps
module hs_load_model (
    // Gate commands and load faults
    input  wire logic [1:0] driverGate,
    input  wire logic [1:0] loadOpen,
    input  wire logic [1:0] loadShort,
    // Indications back to the block
    output logic      [1:0] openLoadRaw,
    output logic      [1:0] currentLimitRaw
);
    // An off switch carries no current, so it reads as open; the block masks it
    assign openLoadRaw     = loadOpen | ~driverGate;
    // Only a conducting switch can reach its limit
    assign currentLimitRaw = loadShort & driverGate;
endmodule : hs_load_model

// file: hdl/high_side_driver_control.sv
// Control and status logic for two high-side power drivers.
// Assumes a single-cycle register port on mclk (address, read and write
// strobes), PWM channels from logic on mclk, and analog indications that
// arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "hs_driver_map.svh"

module high_side_driver_control (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [15:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    output logic             regHit,
    // PWM channels from the PWM module
    input  wire logic [1:0]  pwmChannel,
    // Power mode and cyclic sensing
    input  wire logic        lowPowerMode,
    input  wire logic        cyclicSenseKeep,
    // Analog indications, asynchronous
    input  wire logic        overtempRaw,
    input  wire logic        highVoltageRaw,
    input  wire logic [1:0]  currentLimitRaw,
    input  wire logic [1:0]  openLoadRaw,
    // Driver gate commands to the analog switches
    output logic      [1:0]  driverGate,
    // Toward the interrupt controller
    output logic             overtempFlag,
    output logic             overtempIrq
);

    // Declarations
    // Everything after the synchronisers runs on mclk alone
    logic [7:0]               driverControlReg;
    logic [5:0]               analogSync;
    logic [1:0]               modeSync;
    logic                     lowPowerSync;
    logic                     keepSync;
    logic                     hvTrip;
    logic                     otTrip;
    logic [1:0]               openLoadSeen;
    logic                     overtempCondition;
    logic                     highVoltageCondition;
    logic [1:0]               currentLimit;
    logic [1:0]               openLoad;
    logic                     overtempPrev;
    logic                     overtempShutdown;
    logic                     hvShutdown;
    logic                     next_overtempShutdown;
    logic                     next_hvShutdown;
    logic                     next_overtempFlag;
    logic [1:0]               next_driverGate;
    logic [7:0]               next_regRdata;
    logic [7:0]               driverStatusReg;
    logic                     controlHit;
    logic                     statusHit;
    logic                     controlWrite;
    logic                     statusRead;
    logic                     overtempRise;
    logic                     powerAllowed;
    logic                     shutdownActive;
    logic [1:0]               pwmSelected;
    logic [1:0]               pwmGateOk;
    logic [1:0]               driverRequest;
    hs_driver_pkg::reg_sel_t  regSel;
    hs_driver_pkg::prot_state_t protState;

    // Address decode
    // Unmapped addresses fall through to a zero read, never a fault

    // Both windows alias the same registers; the window only tells the
    // bus whether to stall, which does not matter to this block
    function automatic logic hitsOffset(input logic [15:0] addr,
                                        input logic [7:0]  offset);
        logic [15:0] blockAddr;
        logic [15:0] freeAddr;
        blockAddr = `HSD_BASE_BLOCKING + {8'h00, offset};
        freeAddr  = `HSD_BASE_NONBLOCKING + {8'h00, offset};
        hitsOffset = (addr == blockAddr) || (addr == freeAddr);
    endfunction : hitsOffset

    // Register select
    assign controlHit   = hitsOffset(regAddr, `HSD_OFF_CONTROL);
    assign statusHit    = hitsOffset(regAddr, `HSD_OFF_STATUS);
    assign regHit       = controlHit || statusHit;
    assign regSel       = controlHit ? hs_driver_pkg::SEL_CONTROL :
                          statusHit  ? hs_driver_pkg::SEL_STATUS :
                                       hs_driver_pkg::SEL_NONE;
    assign controlWrite = regWrite && controlHit;
    assign statusRead   = regRead && statusHit;

    // Synchronisation of the analog indications
    // Each bit is a slow level; a glitch may still pass as a short pulse

    // The analog comparators run unclocked, so nothing reads them raw
    sync_two_ff #(
        .WIDTH (6)
    ) u_analog_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .asyncIn ({overtempRaw, highVoltageRaw, currentLimitRaw, openLoadRaw}),
        .syncOut (analogSync)
    );

    // Named views of the synchronised bundle
    assign overtempCondition    = analogSync[5];
    assign highVoltageCondition = analogSync[4];
    assign currentLimit         = analogSync[3:2];
    assign openLoad             = analogSync[1:0];

    // Power mode levels arrive from pins as well, so they pass two flops
    sync_two_ff #(
        .WIDTH (2)
    ) u_mode_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .asyncIn ({lowPowerMode, cyclicSenseKeep}),
        .syncOut (modeSync)
    );

    // Named views of the mode bundle
    assign lowPowerSync = modeSync[1];
    assign keepSync     = modeSync[0];

    // Control register
    // Plain storage; every field acts through the logic further down

    // Software control register; all fields plain read/write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            driverControlReg <= `HSD_CONTROL_RESET;
        end else if (controlWrite) begin
            driverControlReg <= regWdata;
        end
    end

    // Shutdown latches
    // A write re-arms only the causes whose conditions have gone away

    // A condition that is still present when the control write lands
    // keeps the latch set, so the write cannot defeat the protection
    assign next_overtempShutdown =
        overtempCondition ||
        (overtempShutdown && !controlWrite);
    // High voltage trips only while its enable bit is set
    assign hvTrip = highVoltageCondition &&
                    driverControlReg[`HSD_CTL_HV_SD_EN];
    assign next_hvShutdown =
        hvTrip ||
        (hvShutdown && !controlWrite);

    // Protection latches
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            overtempShutdown <= 1'b0;
            hvShutdown       <= 1'b0;
        end else begin
            overtempShutdown <= next_overtempShutdown;
            hvShutdown       <= next_hvShutdown;
        end
    end

    // Summary state, overtemperature named first when both are held
    assign protState = overtempShutdown ? hs_driver_pkg::PROT_OT_OFF :
                       hvShutdown       ? hs_driver_pkg::PROT_HV_OFF :
                                          hs_driver_pkg::PROT_RUN;

    // Overtemperature acts through its live level and its latch alike
    assign otTrip = overtempCondition || overtempShutdown;

    // Live conditions cut the drivers one mclk after they are seen, without waiting for the latch
    assign shutdownActive =
        otTrip ||
        hvTrip ||
        (protState != hs_driver_pkg::PROT_RUN);

    // Driver gating
    // PWM edges reach the switches one mclk after the channel input

    // In Sleep or Stop the drivers run only when cyclic sensing asks
    assign powerAllowed = !lowPowerSync || keepSync;

    // PWM level picked by one select bit; shared by both drivers
    function automatic logic pwmPick(input logic       chanSel,
                                     input logic [1:0] channels);
        pwmPick = chanSel ? channels[1] : channels[0];
    endfunction : pwmPick

    // Channel choice per driver
    assign pwmSelected[0] = pwmPick(driverControlReg[`HSD_CTL_PWM_SEL_ONE], pwmChannel);
    assign pwmSelected[1] = pwmPick(driverControlReg[`HSD_CTL_PWM_SEL_TWO], pwmChannel);

    // Without gating the driver follows its enable bit alone
    assign pwmGateOk[0] = !driverControlReg[`HSD_CTL_PWM_GATE_ONE] ||
                          pwmSelected[0];
    assign pwmGateOk[1] = !driverControlReg[`HSD_CTL_PWM_GATE_TWO] ||
                          pwmSelected[1];

    // Software enables
    assign driverRequest[0] = driverControlReg[`HSD_CTL_DRV_ONE_ON];
    assign driverRequest[1] = driverControlReg[`HSD_CTL_DRV_TWO_ON];

    // Final gate per driver, both cut together by any shutdown
    assign next_driverGate = (driverRequest & pwmGateOk) &
                             {2{powerAllowed && !shutdownActive}};

    // Registered gate so the analog switches see no decode glitches
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            driverGate <= 2'b00;
        end else begin
            driverGate <= next_driverGate;
        end
    end

    // Overtemperature interrupt flag
    // Level toward the interrupt controller; a status read clears it

    // Edge of the synchronised condition marks one event
    assign overtempRise = overtempCondition && !overtempPrev;

    // A new event in the clearing read cycle survives the read
    assign next_overtempFlag = overtempRise ||
                               (overtempFlag && !statusRead);

    // Event latch and edge history
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            overtempPrev <= 1'b0;
            overtempFlag <= 1'b0;
        end else begin
            overtempPrev <= overtempCondition;
            overtempFlag <= next_overtempFlag;
        end
    end

    // Mask only the request; the latched flag stays visible upstream
    assign overtempIrq = overtempFlag &&
                         driverControlReg[`HSD_CTL_OT_IRQ_EN];

    // Status register and read data
    // Status is rebuilt each cycle from synchronised levels, nothing sticky

    // Open load means nothing while the output is off, PWM off phase too
    assign openLoadSeen = openLoad & driverGate;

    // Status byte assembled from the synchronised levels
    always_comb begin
        driverStatusReg = `HSD_STATUS_RESET;
        driverStatusReg[`HSD_STS_OT_COND]  = overtempCondition;
        driverStatusReg[`HSD_STS_CLIM_TWO] = currentLimit[1];
        driverStatusReg[`HSD_STS_CLIM_ONE] = currentLimit[0];
        driverStatusReg[`HSD_STS_OPEN_TWO] = openLoadSeen[1];
        driverStatusReg[`HSD_STS_OPEN_ONE] = openLoadSeen[0];
    end

    // Read data mux; unmapped addresses return zero
    always_comb begin
        unique case (regSel)
            hs_driver_pkg::SEL_CONTROL: begin
                next_regRdata = driverControlReg;
            end
            hs_driver_pkg::SEL_STATUS: begin
                next_regRdata = driverStatusReg;
            end
            hs_driver_pkg::SEL_NONE: begin
                next_regRdata = 8'h00;
            end
            default: begin
                next_regRdata = 8'h00;
            end
        endcase
    end

    // Read data is held until the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_regRdata;
        end
    end

endmodule : high_side_driver_control

// file: hdl/hs_driver_map.svh
// Register map, field positions, reset values and decode bases of the
// high-side driver control block.
// Assumes the register port carries a 16-bit global byte address.
`ifndef HS_DRIVER_MAP_SVH
`define HS_DRIVER_MAP_SVH

// Global bases: blocking and non-blocking windows
`define HSD_BASE_BLOCKING      16'h0200
`define HSD_BASE_NONBLOCKING   16'h0300

// Register offsets inside either window
`define HSD_OFF_CONTROL        8'h28
`define HSD_OFF_STATUS         8'h29

// Reset values
`define HSD_CONTROL_RESET      8'h00
`define HSD_STATUS_RESET       8'h00

// Control register fields
`define HSD_CTL_OT_IRQ_EN      7
`define HSD_CTL_HV_SD_EN       6
`define HSD_CTL_PWM_SEL_TWO    5
`define HSD_CTL_PWM_SEL_ONE    4
`define HSD_CTL_PWM_GATE_TWO   3
`define HSD_CTL_PWM_GATE_ONE   2
`define HSD_CTL_DRV_TWO_ON     1
`define HSD_CTL_DRV_ONE_ON     0

// Status register fields
`define HSD_STS_OT_COND        7
`define HSD_STS_CLIM_TWO       3
`define HSD_STS_CLIM_ONE       2
`define HSD_STS_OPEN_TWO       1
`define HSD_STS_OPEN_ONE       0

`endif

// file: hdl/hs_driver_pkg.sv
// Types shared by the high-side driver control block.
// Assumes hs_driver_map.svh supplies the numeric constants.
package hs_driver_pkg;

    // Which register an access selects, one-hot
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b001,
        SEL_CONTROL = 3'b010,
        SEL_STATUS  = 3'b100
    } reg_sel_t;

    // Protection state of the driver pair, one-hot
    typedef enum logic [2:0] {
        PROT_RUN     = 3'b001,
        PROT_OT_OFF  = 3'b010,
        PROT_HV_OFF  = 3'b100
    } prot_state_t;

endpackage : hs_driver_pkg

// file: hdl/sync_two_ff.sv
// Two-flop synchroniser for a bundle of independent level signals.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps

module sync_two_ff #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] firstStage;

    // First stage is read by the second stage only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            firstStage <= '0;
            syncOut    <= '0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule : sync_two_ff
